// [common/driver_cfg_pkg.sv]
// Shared constants for the serial frame handler and configuration bank.
// Assumes a 16-bit frame and a 5-bit register address space.
package driver_cfg_pkg;

  // ==========================================================
  // Frame layout
  localparam int FRAME_W = 16;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int COUNT_W = 5;
  localparam int FLAG_BIT = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 10;
  localparam int DATA_HI = 9;
  localparam int DATA_LO = 2;
  localparam int CHECK_BIT = 1;
  localparam int TOGGLE_BIT = 0;
  localparam logic [COUNT_W-1:0] FULL_COUNT = 5'h10;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_PART_ID = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_SIDE_MASK = 5'h01;
  localparam logic [ADDR_W-1:0] OFS_RESET_LED = 5'h02;
  localparam logic [ADDR_W-1:0] OFS_GEN_TRIM = 5'h03;
  localparam logic [ADDR_W-1:0] OFS_INRUSH = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_RESERVED_A = 5'h05;
  localparam logic [ADDR_W-1:0] OFS_DIRECT = 5'h06;
  localparam logic [ADDR_W-1:0] OFS_MAP_A = 5'h07;
  localparam logic [ADDR_W-1:0] OFS_MAP_B = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_MAP_PWM = 5'h09;
  localparam int LAST_CFG = 9;

  // ==========================================================
  // Field positions
  localparam int SIDE_LSB = 2;
  localparam int KILL_UNMASK_BIT = 1;
  localparam int EXT_RST_UNMASK_BIT = 0;
  localparam int SOFT_RESET_BIT = 7;
  localparam int STAY_AWAKE_BIT = 6;
  localparam int RATE_LSB = 0;
  localparam int TRIM_LSB = 2;

  // ==========================================================
  // Reset values and storable bits
  localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] RST_MAP_A = 8'h04;
  localparam logic [DATA_W-1:0] RST_MAP_B = 8'h08;
  localparam logic [DATA_W-1:0] MASK_ALL = 8'hFF;
  localparam logic [DATA_W-1:0] MASK_RESET_LED = 8'h43;
  localparam logic [DATA_W-1:0] MASK_GEN_TRIM = 8'h0F;

endpackage

// [common/link_if.sv]
// Carrier between the serial-clock shifter and the core frame logic.
// Words are quasi-static: each side reads them only while the other holds.
`timescale 1ns/1ps
interface link_if;
  logic [driver_cfg_pkg::FRAME_W-1:0] rx_word;
  logic [driver_cfg_pkg::COUNT_W-1:0] bit_count;
  logic start_toggle;
  logic [driver_cfg_pkg::FRAME_W-1:0] reply_word;

  modport link
  (
    output rx_word,
    output bit_count,
    output start_toggle,
    input reply_word
  );

  modport core
  (
    input rx_word,
    input bit_count,
    input start_toggle,
    output reply_word
  );
endinterface

// [rtl/bit_sync.sv]
// Two-stage level synchroniser for a bundle of independent bits.
// Assumes each bit is a slow level; no bus coherence is promised.
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_reg;

  // ==========================================================
  // First stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_reg <= RST_VAL;
      o_q <= RST_VAL;
    end
    else
    begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end

endmodule // bit_sync

// [rtl/spi_link_shifter.sv]
// Serial-clock side of the frame handler: shifts in, counts, shifts out.
// Assumes mode 0 framing; the serial clock runs only inside a frame.
`timescale 1ns/1ps
module spi_link_shifter (
  input wire logic i_sclk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  link_if.link lk
);

  logic armed_reg;
  logic out_bit_reg;

  // ==========================================================
  // Armed between frames and after reset, cleared by the first clock;
  // reset arms it too, since select may never rise before frame one
  always_ff @(posedge i_sclk or posedge i_cs_n or negedge i_rst_n)
  begin
    if (!i_rst_n)
      armed_reg <= 1'b1;
    else if (i_cs_n)
      armed_reg <= 1'b1;
    else
      armed_reg <= 1'b0;
  end

  // Shift in on rising edge; keep the newest 16 bits
  always_ff @(posedge i_sclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      lk.rx_word <= '0;
      lk.bit_count <= '0;
      lk.start_toggle <= 1'b0;
    end
    else
    begin
      lk.rx_word <= {lk.rx_word[driver_cfg_pkg::FRAME_W-2:0], i_mosi};
      if (armed_reg)
      begin
        lk.bit_count <= 5'h01;
        lk.start_toggle <= ~lk.start_toggle;
      end
      else if (lk.bit_count != driver_cfg_pkg::FULL_COUNT)
        lk.bit_count <= lk.bit_count + 5'h01; // Saturates for long frames
    end
  end

  // Next bit on falling edge; past 16 bits pass the chain through
  always_ff @(negedge i_sclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      out_bit_reg <= 1'b0;
    else if (lk.bit_count < driver_cfg_pkg::FULL_COUNT)
      out_bit_reg <= lk.reply_word[4'hF - lk.bit_count[3:0]];
    else
      out_bit_reg <= lk.rx_word[driver_cfg_pkg::FRAME_W-1];
  end

  // First bit must stand before the first rising edge
  assign o_miso = armed_reg ? lk.reply_word[driver_cfg_pkg::FLAG_BIT]
                            : out_bit_reg;
  assign o_miso_oe = ~i_cs_n;

endmodule // spi_link_shifter

// [rtl/driver_spi_frame_config_regs.sv]
// Serial frame checker and lower configuration register bank of an
// eight-channel output driver.
// Assumes the serial clock idles outside frames and the master leaves
// at least a few core cycles between the end of one frame and the next.
`timescale 1ns/1ps

// Operation
// - Frame bit 15 high asks for a write, low for a read.
// - Frame: flag, 5-bit address, 8 data bits, check bit, toggle bit.
// - Bits 15 down to 1 together hold an odd number of ones.
// - Bit 0 carries the frame toggle counter, both directions.
// - Reply bit 15 reports a fault in the previous transfer.
// - Reply uses the same 16-bit layout as the request.
// - Offset 0x00 reads a fixed part identifier, untouched by resets.
// - Offset 0x01 bits 7..2 choose high side per channel.
// - Offset 0x01 bit 1 unmasks the channel-kill pin.
// - Offset 0x01 bit 0 unmasks the external reset pin.
// - Writing one to offset 0x02 bit 7 resets; self clearing.
// - Power-on, reset pin, soft reset, undervoltage restore defaults.
// - Offset 0x02 bit 6 holds the device in active mode.
// - Two 2-bit rate fields pick one of four PWM rates.
// - Offset 0x03 bits 3..2 trim rate down or up by 15 percent.
// - Offset 0x04 enables inrush mode per channel.
// - Offset 0x05 reads zero and stores nothing.
// - Offset 0x06 switches each channel directly.
// - Offset 0x07 maps input A to channels; default channel 2.
// - Offset 0x08 maps input B to channels; default channel 3.
// - Offset 0x09 maps the PWM generator to channels; none by default.
// - Bit n of a channel register belongs to channel n.
// - Toggle counter starts at zero after reset; mismatch is a fault.
// - Fewer than 16 clocks: discard frame, fault next reply.
// - More than 16 clocks: keep the last 16 bits.
// - Each reply answers the request of the previous frame.
module driver_spi_frame_config_regs #(
  parameter logic [7:0] PART_ID = 8'hC3 // Arbitrary value
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_external_reset_pin_n,
  input wire logic i_logic_supply_undervoltage,
  output logic [7:2] o_high_side_select,
  output logic o_kill_pin_unmask,
  output logic o_ext_reset_unmask,
  output logic o_device_reset,
  output logic o_stay_awake_request,
  output logic [1:0] o_led_pwm_rate_select,
  output logic [1:0] o_general_pwm_rate_select,
  output logic [1:0] o_pwm_rate_trim,
  output logic [7:0] o_inrush_mode,
  output logic [7:0] o_direct_output_control,
  output logic [7:0] o_input_a_channel_map,
  output logic [7:0] o_input_b_channel_map,
  output logic [7:0] o_pwm_generator_channel_map
);

  // ==========================================================
  // Declarations
  logic [1:0] rst_pipe_reg;
  logic rst_n;
  logic [3:0] sync_in;
  logic [3:0] sync_out;
  logic cs_n_s;
  logic toggle_s;
  logic ext_reset_n_s;
  logic undervoltage_s;
  logic cs_n_prev_reg;
  logic frame_end;
  logic last_toggle_reg;
  logic clocked;
  logic complete;
  logic check_ok;
  logic count_ok;
  logic fault;
  logic write_ok;
  logic expect_toggle_reg;
  logic reply_toggle_reg;
  logic soft_reset_reg;
  logic cfg_clear;
  logic [4:0] req_addr;
  logic [7:0] req_data;
  logic [7:0] cfg_reg [1:driver_cfg_pkg::LAST_CFG];
  logic [7:0] side_cfg;
  logic [7:0] led_cfg;
  logic [7:0] gen_cfg;

  link_if lk ();

  // ==========================================================
  // Helper functions

  // Bits of each offset that hold state
  function automatic logic [7:0] store_mask(input logic [4:0] a);
    logic [7:0] m;
    m = driver_cfg_pkg::RST_ZERO;
    unique case (a)
      driver_cfg_pkg::OFS_SIDE_MASK: m = driver_cfg_pkg::MASK_ALL;
      driver_cfg_pkg::OFS_RESET_LED: m = driver_cfg_pkg::MASK_RESET_LED;
      driver_cfg_pkg::OFS_GEN_TRIM: m = driver_cfg_pkg::MASK_GEN_TRIM;
      driver_cfg_pkg::OFS_INRUSH: m = driver_cfg_pkg::MASK_ALL;
      driver_cfg_pkg::OFS_DIRECT: m = driver_cfg_pkg::MASK_ALL;
      driver_cfg_pkg::OFS_MAP_A: m = driver_cfg_pkg::MASK_ALL;
      driver_cfg_pkg::OFS_MAP_B: m = driver_cfg_pkg::MASK_ALL;
      driver_cfg_pkg::OFS_MAP_PWM: m = driver_cfg_pkg::MASK_ALL;
      default: m = driver_cfg_pkg::RST_ZERO;
    endcase
    return m;
  endfunction

  // Default contents of each offset
  function automatic logic [7:0] reset_value(input logic [4:0] a);
    logic [7:0] v;
    v = driver_cfg_pkg::RST_ZERO;
    if (a == driver_cfg_pkg::OFS_MAP_A)
      v = driver_cfg_pkg::RST_MAP_A;
    else if (a == driver_cfg_pkg::OFS_MAP_B)
      v = driver_cfg_pkg::RST_MAP_B;
    return v;
  endfunction

  // Odd check over bits 15..2 of a frame
  function automatic logic odd_check_bit(input logic [15:2] upper);
    return ~(^upper);
  endfunction

  // Assemble a reply frame in request layout
  function automatic logic [15:0] make_reply(input logic err,
                                             input logic [4:0] a,
                                             input logic [7:0] d,
                                             input logic tog);
    logic [15:2] upper;
    upper = {err, a, d};
    return {upper, odd_check_bit(upper), tog};
  endfunction

  // ==========================================================
  // Reset release
  // Assert at once, release through two core-clock stages
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rst_pipe_reg <= 2'b00;
    else
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
  end

  assign rst_n = rst_pipe_reg[1];

  // ==========================================================
  // Serial link and crossings
  // Link regs reset from the core copy; the serial clock is idle then
  spi_link_shifter u_shifter (
    .i_sclk(i_sclk),
    .i_rst_n(rst_n),
    .i_cs_n(i_cs_n),
    .i_mosi(i_mosi),
    .o_miso(o_miso),
    .o_miso_oe(o_miso_oe),
    .lk(lk.link)
  );

  // Select, frame-start toggle and pins enter through two stages
  assign sync_in = {i_cs_n, lk.start_toggle, i_external_reset_pin_n,
                    i_logic_supply_undervoltage};

  bit_sync #(
    .W(4),
    .RST_VAL(4'hA)
  ) u_sync (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_d(sync_in),
    .o_q(sync_out)
  );

  assign cs_n_s = sync_out[3];
  assign toggle_s = sync_out[2];
  assign ext_reset_n_s = sync_out[1];
  assign undervoltage_s = sync_out[0];

  // ==========================================================
  // Frame end detection
  // Rising select ends the frame; link words are then frozen
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cs_n_prev_reg <= 1'b1;
    else
      cs_n_prev_reg <= cs_n_s;
  end

  assign frame_end = cs_n_s & ~cs_n_prev_reg;

  // Toggle seen at the previous frame end; no change means no clocks
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      last_toggle_reg <= 1'b0;
    else if (frame_end)
      last_toggle_reg <= toggle_s;
  end

  // ==========================================================
  // Frame checks
  assign clocked = toggle_s != last_toggle_reg;
  assign complete = clocked
                    && (lk.bit_count == driver_cfg_pkg::FULL_COUNT);
  assign check_ok = odd_check_bit(lk.rx_word[15:2])
                    == lk.rx_word[driver_cfg_pkg::CHECK_BIT];
  assign count_ok = lk.rx_word[driver_cfg_pkg::TOGGLE_BIT]
                    == expect_toggle_reg;
  assign fault = ~complete | ~check_ok | ~count_ok;
  assign write_ok = frame_end & ~fault
                    & lk.rx_word[driver_cfg_pkg::FLAG_BIT];
  assign req_addr = lk.rx_word[driver_cfg_pkg::ADDR_HI:
                               driver_cfg_pkg::ADDR_LO];
  assign req_data = lk.rx_word[driver_cfg_pkg::DATA_HI:
                               driver_cfg_pkg::DATA_LO];

  // ==========================================================
  // Reset sources
  // Soft reset acts one cycle after the write; the bit never stores
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      soft_reset_reg <= 1'b0;
    else
      soft_reset_reg <= write_ok
                        && req_addr == driver_cfg_pkg::OFS_RESET_LED
                        && req_data[driver_cfg_pkg::SOFT_RESET_BIT];
  end

  // Pin reset counts only while unmasked
  assign cfg_clear = soft_reset_reg
                     | (o_ext_reset_unmask & ~ext_reset_n_s)
                     | undervoltage_s;

  // ==========================================================
  // Toggle counters
  // Expected toggle flips on every full-length frame, good or bad
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      expect_toggle_reg <= 1'b0;
    else if (cfg_clear)
      expect_toggle_reg <= 1'b0;
    else if (frame_end && complete)
      expect_toggle_reg <= ~expect_toggle_reg;
  end

  // Own reply counter, also zero after any reset
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reply_toggle_reg <= 1'b0;
    else if (cfg_clear)
      reply_toggle_reg <= 1'b0;
    else if (frame_end)
      reply_toggle_reg <= ~reply_toggle_reg;
  end

  // ==========================================================
  // Configuration store
  // Clear beats a write; a faulty frame writes nothing
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 1; i <= driver_cfg_pkg::LAST_CFG; i++)
        cfg_reg[i] <= reset_value(5'(i));
    end
    else if (cfg_clear)
    begin
      for (int i = 1; i <= driver_cfg_pkg::LAST_CFG; i++)
        cfg_reg[i] <= reset_value(5'(i));
    end
    else if (write_ok && req_addr != driver_cfg_pkg::OFS_PART_ID
             && req_addr <= 5'(driver_cfg_pkg::LAST_CFG))
    begin
      cfg_reg[req_addr] <= req_data & store_mask(req_addr);
    end
  end

  // Read view; identifier is a constant, immune to every reset
  function automatic logic [7:0] read_reg(input logic [4:0] a);
    logic [7:0] v;
    v = driver_cfg_pkg::RST_ZERO;
    if (a == driver_cfg_pkg::OFS_PART_ID)
      v = PART_ID;
    else if (a <= 5'(driver_cfg_pkg::LAST_CFG))
      v = cfg_reg[a] & store_mask(a);
    return v;
  endfunction

  // ==========================================================
  // Reply word
  // Built at frame end and held for the next frame to shift out;
  // a write answers with the contents before the write
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      lk.reply_word <= make_reply(1'b0, 5'h00, 8'h00, 1'b0);
    else if (frame_end)
      lk.reply_word <= make_reply(fault, req_addr,
                                  fault ? 8'h00 : read_reg(req_addr),
                                  reply_toggle_reg);
  end

  // ==========================================================
  // Field outputs
  // Bit n of each channel register drives channel n
  assign side_cfg = cfg_reg[driver_cfg_pkg::OFS_SIDE_MASK];
  assign led_cfg = cfg_reg[driver_cfg_pkg::OFS_RESET_LED];
  assign gen_cfg = cfg_reg[driver_cfg_pkg::OFS_GEN_TRIM];

  assign o_high_side_select = side_cfg[7:driver_cfg_pkg::SIDE_LSB];
  assign o_kill_pin_unmask =
    side_cfg[driver_cfg_pkg::KILL_UNMASK_BIT];
  assign o_ext_reset_unmask =
    side_cfg[driver_cfg_pkg::EXT_RST_UNMASK_BIT];
  assign o_device_reset = soft_reset_reg;
  assign o_stay_awake_request =
    led_cfg[driver_cfg_pkg::STAY_AWAKE_BIT];
  assign o_led_pwm_rate_select =
    led_cfg[driver_cfg_pkg::RATE_LSB+:2];
  assign o_general_pwm_rate_select =
    gen_cfg[driver_cfg_pkg::RATE_LSB+:2];
  assign o_pwm_rate_trim = gen_cfg[driver_cfg_pkg::TRIM_LSB+:2];
  assign o_inrush_mode = cfg_reg[driver_cfg_pkg::OFS_INRUSH];
  assign o_direct_output_control =
    cfg_reg[driver_cfg_pkg::OFS_DIRECT];
  assign o_input_a_channel_map = cfg_reg[driver_cfg_pkg::OFS_MAP_A];
  assign o_input_b_channel_map = cfg_reg[driver_cfg_pkg::OFS_MAP_B];
  assign o_pwm_generator_channel_map =
    cfg_reg[driver_cfg_pkg::OFS_MAP_PWM];

endmodule // driver_spi_frame_config_regs

// [verif/spi_master_model.sv]
// Serial master model: mode 0, MSB first, 15 ns serial clock.
// Assumes the bench resolves the data-out wire onto i_miso.
`timescale 1ns/1ps
module spi_master_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  // ==========================================
  // Idle levels: clock low, select high
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end

  // One transfer of n bits; the clock stands still outside it
  task automatic xfer(input int n, input logic [31:0] w,
                      output logic [31:0] r);
    r = '0;
    o_cs_n = 1'b0;
    #200;
    for (int k = n - 1; k >= 0; k--)
    begin
      o_mosi = w[k];
      #7.5 r = {r[30:0], i_miso}; // Taken just before the rising edge
      o_sclk = 1'b1;
      #7.5 o_sclk = 1'b0;
    end
    #200 o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // Released line must not look stale
    #700;
  endtask
endmodule // spi_master_model

// [verif/driver_cfg_sva.sv]
// Checker on the top ports of the frame handler and config bank.
// Assumes pins change only while the select line is high.
`timescale 1ns/1ps
module driver_cfg_sva (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_cs_n,
  input wire logic i_external_reset_pin_n,
  input wire logic i_logic_supply_undervoltage,
  input wire logic o_miso_oe,
  input wire logic o_ext_reset_unmask,
  input wire logic o_device_reset,
  input wire logic o_stay_awake_request,
  input wire logic [7:0] o_inrush_mode,
  input wire logic [7:0] o_direct_output_control,
  input wire logic [7:0] o_input_a_channel_map,
  input wire logic [7:0] o_input_b_channel_map,
  input wire logic [7:0] o_pwm_generator_channel_map
);
  // ==========================================
  // One clock domain for every property
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  oe_tracks_select_a: assert property (o_miso_oe == !i_cs_n)
    else $error("data out enable does not follow select");
  reset_defaults_a: assert property ($rose(i_resetn) |->
    o_input_a_channel_map == 8'h04 && o_input_b_channel_map == 8'h08)
    else $error("maps not at defaults after reset");
  undervolt_clear_a: assert property (i_logic_supply_undervoltage [*5] |->
    o_direct_output_control == 8'h00 && o_inrush_mode == 8'h00)
    else $error("undervoltage did not clear outputs");
  pin_clear_a: assert property (o_ext_reset_unmask &&
    !i_external_reset_pin_n |-> ##[1:4] !o_ext_reset_unmask)
    else $error("unmasked reset pin had no effect");
  pulse_single_a: assert property (o_device_reset |=> !o_device_reset)
    else $error("soft reset pulse too long");
  soft_clear_a: assert property (o_device_reset |-> ##[0:2]
    o_pwm_generator_channel_map == 8'h00 && !o_stay_awake_request)
    else $error("soft reset did not clear config");
  pulse_after_frame_a: assert property (o_device_reset |->
    i_cs_n && $past(i_cs_n, 2))
    else $error("soft reset pulse inside a frame");
  quiet_in_frame_a: assert property (!$stable({o_direct_output_control,
    o_pwm_generator_channel_map}) |-> i_cs_n)
    else $error("config changed while a frame was open");

  // ==========================================
  // Main scenarios reached
  cover property (o_device_reset);
  cover property ($fell(o_ext_reset_unmask));
  cover property (i_logic_supply_undervoltage [*5]);
endmodule // driver_cfg_sva

bind driver_spi_frame_config_regs driver_cfg_sva chk (.i_core_clk,
  .i_resetn, .i_cs_n, .i_external_reset_pin_n,
  .i_logic_supply_undervoltage, .o_miso_oe, .o_ext_reset_unmask,
  .o_device_reset, .o_stay_awake_request, .o_inrush_mode,
  .o_direct_output_control, .o_input_a_channel_map,
  .o_input_b_channel_map, .o_pwm_generator_channel_map);

// [verif/testbench.sv]
// Self-checking bench: frames, faults, clears and daisy chaining.
// Assumes the serial master model and the bound checker.
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] ID = 8'h5A; // Arbitrary value
  logic clk, rst_n, pin_n, uv, miso, oe, kill, xru, dres, act;
  logic [7:2] hs;
  logic [1:0] led, gen, trim;
  logic [7:0] inr, dir, ma, mb, mp;
  wire logic sclk, cs_n, mosi, miso_w;
  int errors, num_checks, cyc;
  logic [7:0] regs[10];
  logic [15:0] pend, pmask;
  logic et, rt;
  logic [31:0] r;
  logic [4:0] a5;

  driver_spi_frame_config_regs #(.PART_ID(ID)) uut (.i_core_clk(clk),
    .i_resetn(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi),
    .o_miso(miso), .o_miso_oe(oe), .i_external_reset_pin_n(pin_n),
    .i_logic_supply_undervoltage(uv), .o_high_side_select(hs),
    .o_kill_pin_unmask(kill), .o_ext_reset_unmask(xru),
    .o_device_reset(dres), .o_stay_awake_request(act),
    .o_led_pwm_rate_select(led), .o_general_pwm_rate_select(gen),
    .o_pwm_rate_trim(trim), .o_inrush_mode(inr),
    .o_direct_output_control(dir), .o_input_a_channel_map(ma),
    .o_input_b_channel_map(mb), .o_pwm_generator_channel_map(mp));
  spi_master_model m (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
    .i_miso(miso_w));
  assign miso_w = oe ? miso : 1'bz;

  // ==========================================
  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      errors++;
      report_and_stop();
    end
  end

  // ==========================================
  // Reference model
  function automatic logic [15:0] mk(logic w1, logic [4:0] a,
                                     logic [7:0] d, logic t);
    return {w1, a, d, ~^{w1, a, d}, t};
  endfunction
  task automatic defaults();
    foreach (regs[i]) regs[i] = 8'h00;
    regs[0] = ID;
    regs[7] = 8'h04;
    regs[8] = 8'h08;
    et = 1'b0;
    rt = 1'b0;
  endtask
  task automatic cmp(logic [63:0] got, logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_out();
    cmp({hs, kill, xru, act, led, gen, trim, inr, dir, ma, mb, mp},
      {regs[1], regs[2][6], regs[2][1:0], regs[3][1:0], regs[3][3:2],
       regs[4], regs[6], regs[7], regs[8], regs[9]});
  endtask
  task automatic frame(int n, logic [31:0] w);
    logic [15:0] top, f;
    logic [7:0] dat;
    logic [4:0] a;
    logic bad;
    m.xfer(n, w, r);
    top = n >= 16 ? 16'(r >> (n - 16)) : 16'(r << (16 - n));
    f = n >= 16 ? 16'hFFFF : ~(16'hFFFF >> n);
    cmp(top & pmask & f, pend & pmask & f);
    if (n > 16)
      cmp(r & ((1 << (n - 16)) - 1), w >> 16);
    a = w[14:10];
    bad = n < 16 || (^w[15:1]) !== 1'b1 || w[0] !== et;
    dat = a <= 5'h09 ? regs[a] : 8'h00;
    if (!bad && w[15] && a inside {[5'h01:5'h04], [5'h06:5'h09]})
      regs[a] = w[9:2] & (a == 5'h02 ? 8'h43 : a == 5'h03 ? 8'h0F : 8'hFF);
    pend = mk(bad, a, bad ? 8'h00 : dat, rt);
    pmask = n < 16 ? 16'h83FD : 16'hFFFF; // Short frame address unknown
    rt = ~rt;
    if (n >= 16)
      et = ~et;
    if (!bad && w[15] && a == 5'h02 && w[9])
      defaults();
  endtask
  task automatic op(logic w1, logic [4:0] a, logic [7:0] d);
    frame(16, mk(w1, a, d, et));
  endtask
  task automatic hold_pin();
    @(posedge clk) pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    pin_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    defaults();
    pend = 16'h0002;
    pmask = 16'hFFFF;
    repeat (10) @(posedge clk);
  endtask
  task automatic report_and_stop();
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    r = $urandom(32'hFCF5);
    errors = 0;
    num_checks = 0;
    cyc = 0;
    rst_n = 1'b0;
    pin_n = 1'b1;
    uv = 1'b0;
    do_reset();
    for (int a = 0; a < 32; a++)
      op(1'b0, a[4:0], 8'(a));
    chk_out();
    for (int k = 0; k < 40; k++)
    begin
      a5 = 5'($urandom_range(10));
      op(1'($urandom), a5, 8'($urandom));
      chk_out();
    end
    for (int k = 0; k < 4; k++)
    begin
      op(1'b1, 5'h02, 8'h40 | 8'(k));
      op(1'b1, 5'h03, 8'(k * 5));
      chk_out();
    end
    op(1'b1, 5'h02, 8'hC3);
    chk_out();
    op(1'b1, 5'h06, 8'hA5);
    frame(16, mk(1'b1, 5'h06, 8'h5A, et) ^ 16'h0002);
    frame(16, mk(1'b1, 5'h06, 8'h3C, ~et));
    frame(8, 32'h00A5);
    frame(0, 32'h0000);
    frame(24, {16'h00C5, mk(1'b1, 5'h07, 8'h3C, et)});
    op(1'b0, 5'h07, 8'h00);
    chk_out();
    op(1'b1, 5'h09, 8'hFF);
    @(posedge clk) uv <= 1'b1;
    repeat (8) @(posedge clk);
    uv <= 1'b0;
    defaults();
    repeat (6) @(posedge clk);
    chk_out();
    op(1'b1, 5'h04, 8'hF0);
    hold_pin();
    chk_out();
    op(1'b1, 5'h01, 8'h01);
    hold_pin();
    defaults();
    chk_out();
    op(1'b1, 5'h08, 8'h81);
    @(posedge clk);
    do_reset();
    op(1'b0, 5'h08, 8'h00);
    op(1'b0, 5'h00, 8'h00);
    chk_out();
    report_and_stop();
  end
endmodule // testbench
